// ---- verilog/tpg_test_pattern_generator.sv ----
// Test pattern generator placed ahead of the digital pixel chain
//
// Operation
// [RL1] A selector holds off or one of five pattern codes; off passes the sensor image.
// [RL2] With a pattern selected, pixel values come from internal logic, not the sensor path.
// [RL3] With a pattern selected, analog gain, black level and exposure cannot affect pixels.
// [RL4] Patterns 1 to 3 go around the digital processing stages on a bypass output.
// [RL5] Patterns 4 and 5 are fed into the digital processing stages.
// [RL6] Pattern 1 is (column + row) modulo 256, fixed.
// [RL7] Pattern 2 is (column + row + frame counter) modulo 256.
// [RL8] The frame counter steps by one at each newly started acquisition.
// [RL9] Pattern 3 is (column + row + frame counter) modulo 4096.
// [RL10] Pattern 4 is the pattern 2 gradient sent through the processing stages.
// [RL11] Pattern 5 is the pattern 3 gradient sent through the processing stages.
// [RL12] The frame counter is 12 bits wide and wraps silently.
// [RL13] Row and column restart at zero on the first pixel of each frame.
`timescale 1ns/10ps
`default_nettype none

module tpg_test_pattern_generator
    import tpg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] patternSelect,
    input wire logic acqStart,
    input wire tpg_pix_type sensorIn,
    output tpg_pix_type procOut,
    output tpg_pix_type bypassOut,
    output logic bypassSel
);

    tpg_state_type state_r;
    tpg_state_type state_nxt;

    // ------------------------------------------------------------
    // Pattern arithmetic
    // ------------------------------------------------------------
    logic [11:0] sumFixed;
    logic [11:0] sumMove;
    logic [11:0] colNow;
    logic [11:0] rowNow;
    logic [11:0] genPix;
    logic genOn;
    logic genByp;

    always_comb
    begin
        state_nxt = state_r;
        // [RL13] Index restart
        colNow = sensorIn.sof ? TPG_IDX_RST : state_r.col;
        rowNow = sensorIn.sof ? TPG_IDX_RST : state_r.row;
        sumFixed = colNow + rowNow;
        // Counter value before any step this cycle, so a start beside a beat is safe
        sumMove = sumFixed + state_r.cnt;
        genOn = 1'b1;
        genByp = 1'b0;
        genPix = 12'h000;
        // Spare codes decode as off rather than as a sixth pattern
        unique case (patternSelect)
            // [RL6] Fixed gradient
            TPG_SEL_P1:
            begin
                genPix = sumFixed & TPG_MASK8;
                genByp = 1'b1;
            end
            // [RL7] Moving 8 bit
            TPG_SEL_P2:
            begin
                genPix = sumMove & TPG_MASK8;
                genByp = 1'b1;
            end
            // [RL9] Moving 12 bit
            TPG_SEL_P3:
            begin
                genPix = sumMove & TPG_MASK12;
                genByp = 1'b1;
            end
            // [RL10] Processed 8 bit
            TPG_SEL_P4:
            begin
                genPix = sumMove & TPG_MASK8;
            end
            // [RL11] Processed 12 bit
            TPG_SEL_P5:
            begin
                genPix = sumMove & TPG_MASK12;
            end
            default:
            begin
                genOn = 1'b0;
            end
        endcase

        // [RL8] Counter per acquisition
        if (acqStart)
        begin
            // [RL12] Silent wrap
            state_nxt.cnt = state_r.cnt + 12'h001;
        end

        if (sensorIn.valid)
        begin
            state_nxt.st = TPG_ST_RUN;
            if (sensorIn.sof)
            begin
                state_nxt.frameSeen = 1'b1;
            end
            if (sensorIn.eol)
            begin
                state_nxt.col = TPG_IDX_RST;
                state_nxt.row = rowNow + 12'h001;
            end
            else
            begin
                state_nxt.col = colNow + 12'h001;
                state_nxt.row = rowNow;
            end
        end

        // [RL1] Source selection
        state_nxt.procOut = sensorIn;
        state_nxt.bypOut = '0;
        state_nxt.bypSel = 1'b0;
        if (genOn)
        begin
            // [RL2] Internal pixel source
            // [RL3] Analog path unused
            if (genByp)
            begin
                // [RL4] Around processing
                state_nxt.procOut = '0;
                state_nxt.bypOut = sensorIn;
                state_nxt.bypOut.data = genPix;
                state_nxt.bypSel = 1'b1;
            end
            else
            begin
                // [RL5] Through processing
                state_nxt.procOut.data = genPix;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Every output leaves this register, so latency is one cycle in every mode
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r.st <= TPG_ST_IDLE;
            state_r.col <= TPG_IDX_RST;
            state_r.row <= TPG_IDX_RST;
            state_r.cnt <= TPG_CNT_RST;
            state_r.frameSeen <= 1'b0;
            state_r.procOut <= '0;
            state_r.bypOut <= '0;
            state_r.bypSel <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign procOut = state_r.procOut;
    assign bypassOut = state_r.bypOut;
    assign bypassSel = state_r.bypSel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seqFirstPix;
        sensorIn.valid && sensorIn.sof;
    endsequence

    AST_OFF_PASSES: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
        patternSelect == TPG_SEL_OFF |=> procOut == $past(sensorIn) && !bypassSel)
        else $error("off does not pass sensor data");

    AST_GEN_IGNORES_SENSOR: assert property (@(posedge sys_clk) disable iff (rst) // [RL2]
        patternSelect == TPG_SEL_P5 && sensorIn.valid && !sensorIn.sof
        && $past(sensorIn.valid && !sensorIn.eol) && $stable(patternSelect)
        && !$past(acqStart) |=> procOut.data == (($past(procOut.data) + 12'h001) & TPG_MASK12))
        else $error("pattern five does not step along a line");

    AST_BYPASS_ROUTE: assert property (@(posedge sys_clk) disable iff (rst) // [RL4]
        patternSelect inside {TPG_SEL_P1, TPG_SEL_P2, TPG_SEL_P3} |=> bypassSel && !procOut.valid)
        else $error("patterns one to three not bypassed");

    AST_PROC_ROUTE: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
        patternSelect inside {TPG_SEL_P4, TPG_SEL_P5} |=> !bypassSel
        && procOut.valid == $past(sensorIn.valid))
        else $error("patterns four and five not processed");

    AST_BYPASS_TIMING: assert property (@(posedge sys_clk) disable iff (rst) // [RL4]
        patternSelect inside {TPG_SEL_P1, TPG_SEL_P2, TPG_SEL_P3}
        |=> bypassOut.valid == $past(sensorIn.valid) && bypassOut.sof == $past(sensorIn.sof)
        && bypassOut.eol == $past(sensorIn.eol))
        else $error("bypass beat framing differs from the sensor beat");

    AST_BYPASS_IDLE: assert property (@(posedge sys_clk) disable iff (rst) // [RL5]
        !(patternSelect inside {TPG_SEL_P1, TPG_SEL_P2, TPG_SEL_P3})
        |=> bypassOut == '0 && !bypassSel)
        else $error("bypass output active outside patterns one to three");

    // Unused codes fall back to normal image output
    AST_SPARE_OFF: assert property (@(posedge sys_clk) disable iff (rst) // [RL1]
        patternSelect inside {3'h6, 3'h7} |=> procOut == $past(sensorIn) && !bypassSel)
        else $error("spare selector code not treated as off");

    AST_P1_ORIGIN: assert property (@(posedge sys_clk) disable iff (rst) // [RL6]
        seqFirstPix and patternSelect == TPG_SEL_P1 |=> bypassOut.data == 12'h000)
        else $error("pattern one origin not zero");

    AST_P2_ORIGIN: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
        seqFirstPix and patternSelect == TPG_SEL_P2 |=> bypassOut.data == ($past(state_r.cnt) & TPG_MASK8))
        else $error("pattern two origin not counter");

    AST_CNT_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
        acqStart |=> state_r.cnt == $past(state_r.cnt) + 12'h001)
        else $error("counter did not step");

    AST_CNT_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [RL8]
        !acqStart |=> $stable(state_r.cnt))
        else $error("counter moved without acquisition");

    AST_P3_ORIGIN: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        seqFirstPix and patternSelect == TPG_SEL_P3 |=> bypassOut.data == $past(state_r.cnt))
        else $error("pattern three origin not counter");

    AST_P4_ORIGIN: assert property (@(posedge sys_clk) disable iff (rst) // [RL10]
        seqFirstPix and patternSelect == TPG_SEL_P4 |=> procOut.data == ($past(state_r.cnt) & TPG_MASK8))
        else $error("pattern four origin wrong");

    AST_P5_ORIGIN: assert property (@(posedge sys_clk) disable iff (rst) // [RL11]
        seqFirstPix and patternSelect == TPG_SEL_P5 |=> procOut.data == $past(state_r.cnt))
        else $error("pattern five origin wrong");

    AST_IDX_RESTART: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
        seqFirstPix and !sensorIn.eol |=> state_r.col == 12'h001 && state_r.row == 12'h000)
        else $error("indices did not restart");

    AST_ANALOG_FREE: assert property (@(posedge sys_clk) disable iff (rst) // [RL3]
        seqFirstPix and patternSelect == TPG_SEL_P4 && $past(sensorIn.data) != sensorIn.data
        |=> procOut.data == ($past(state_r.cnt) & TPG_MASK8))
        else $error("sensor level leaked into pattern");

    // ------------------------------------------------------------
    // Gradient checks along a line
    // ------------------------------------------------------------
    // A beat whose left neighbour came just before it, with no mode change
    sequence seqInLine;
        sensorIn.valid && !sensorIn.sof && $past(sensorIn.valid && !sensorIn.eol)
        && $stable(patternSelect);
    endsequence

    // No counter term, so an acquisition start must not disturb the step
    AST_P1_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL6]
        seqInLine and patternSelect == TPG_SEL_P1
        |=> bypassOut.data == (($past(bypassOut.data) + 12'h001) & TPG_MASK8))
        else $error("pattern one does not step along a line");

    AST_P2_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL7]
        seqInLine and patternSelect == TPG_SEL_P2 && !$past(acqStart)
        |=> bypassOut.data == (($past(bypassOut.data) + 12'h001) & TPG_MASK8))
        else $error("pattern two does not step along a line");

    AST_P3_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL9]
        seqInLine and patternSelect == TPG_SEL_P3 && !$past(acqStart)
        |=> bypassOut.data == (($past(bypassOut.data) + 12'h001) & TPG_MASK12))
        else $error("pattern three does not step along a line");

    AST_P4_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL10]
        seqInLine and patternSelect == TPG_SEL_P4 && !$past(acqStart)
        |=> procOut.data == (($past(procOut.data) + 12'h001) & TPG_MASK8))
        else $error("pattern four does not step along a line");

    // ------------------------------------------------------------
    // Position checks
    // ------------------------------------------------------------
    AST_COL_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
        sensorIn.valid && !sensorIn.sof && !sensorIn.eol
        |=> state_r.col == $past(state_r.col) + 12'h001 && state_r.row == $past(state_r.row))
        else $error("column did not step");

    AST_ROW_STEP: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
        sensorIn.valid && !sensorIn.sof && sensorIn.eol
        |=> state_r.col == TPG_IDX_RST && state_r.row == $past(state_r.row) + 12'h001)
        else $error("row did not step at line end");

    // Blanking gaps between beats must not skew the gradient
    AST_IDX_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
        !sensorIn.valid |=> $stable(state_r.col) && $stable(state_r.row))
        else $error("position moved without a beat");

    AST_FRAME_SEEN: assert property (@(posedge sys_clk) disable iff (rst) // [RL13]
        seqFirstPix |=> state_r.frameSeen && state_r.st == TPG_ST_RUN)
        else $error("first pixel not recorded");

endmodule : tpg_test_pattern_generator

`default_nettype wire

// ---- verilog/tpg_pkg.sv ----
// Shared types and constants of the test pattern generator
package tpg_pkg;

    localparam int TPG_COL_W = 12;
    localparam int TPG_ROW_W = 12;
    localparam int TPG_PIX_W = 12;
    localparam int TPG_CNT_W = 12;
    localparam logic [11:0] TPG_MASK8 = 12'h0FF;
    localparam logic [11:0] TPG_MASK12 = 12'hFFF;
    localparam logic [11:0] TPG_CNT_RST = 12'h000;
    localparam logic [11:0] TPG_IDX_RST = 12'h000;

    // Pattern selection codes
    typedef enum logic [2:0]
    {
        TPG_SEL_OFF = 3'h0,
        TPG_SEL_P1 = 3'h1,
        TPG_SEL_P2 = 3'h2,
        TPG_SEL_P3 = 3'h3,
        TPG_SEL_P4 = 3'h4,
        TPG_SEL_P5 = 3'h5
    } tpg_sel_type;

    // Pixel beat on a stream
    typedef struct packed {
        logic valid;
        logic sof;
        logic eol;
        logic [11:0] data;
    } tpg_pix_type;

    // Frame position state, one-hot
    typedef enum logic [1:0]
    {
        TPG_ST_IDLE = 2'b01,
        TPG_ST_RUN = 2'b10
    } tpg_st_type;

    typedef struct packed {
        tpg_st_type st;
        logic [11:0] col;
        logic [11:0] row;
        logic [11:0] cnt;
        logic frameSeen;
        tpg_pix_type procOut;
        tpg_pix_type bypOut;
        logic bypSel;
    } tpg_state_type;

endpackage : tpg_pkg

// ---- sim/tpg_pipe_model.sv ----
// Model of the pixel chain behind the generator: lookup table and bypass mux
`timescale 1ns/10ps
`default_nettype none

module tpg_pipe_model
    import tpg_pkg::*;
(
    input wire tpg_pix_type procOut,
    input wire tpg_pix_type bypassOut,
    input wire logic bypassSel,
    output logic [11:0] finalPix
);
    // An inverting table, so that any pass through the chain shows
    always_comb
        finalPix = bypassSel ? bypassOut.data : ~procOut.data;
endmodule : tpg_pipe_model

`default_nettype wire

// ---- sim/tpg_test_pattern_generator_tb_top.sv ----
// Self-checking testbench of the test pattern generator
`timescale 1ns/10ps
`default_nettype none

module tpg_test_pattern_generator_tb_top
    import tpg_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] patternSelect = 3'h0;
    logic acqStart = 1'b0;
    tpg_pix_type sensorIn = '0;
    tpg_pix_type procOut;
    tpg_pix_type bypassOut;
    logic bypassSel;
    logic [11:0] finalPix;
    logic [11:0] cnt = 12'h000;
    int num_errors = 0;
    int cmp_count = 0;

    tpg_test_pattern_generator uut (.sys_clk(sys_clk), .rst(rst),
        .patternSelect(patternSelect), .acqStart(acqStart), .sensorIn(sensorIn),
        .procOut(procOut), .bypassOut(bypassOut), .bypassSel(bypassSel));
    tpg_pipe_model chain (.procOut(procOut), .bypassOut(bypassOut),
        .bypassSel(bypassSel), .finalPix(finalPix));

    initial
        forever #2.5 sys_clk = ~sys_clk;

    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic beat(input logic s, input logic e, input logic [11:0] c, input logic [11:0] r);
        tpg_pix_type inBeat;
        tpg_pix_type gen;
        logic [11:0] sum;
        inBeat = '{valid: 1'b1, sof: s, eol: e, data: 12'hA5A ^ c};
        sum = c + r + ((patternSelect == 3'h1) ? 12'h000 : cnt);
        gen = '{valid: 1'b1, sof: s, eol: e,
            data: sum & ((patternSelect inside {3'h3, 3'h5}) ? TPG_MASK12 : TPG_MASK8)};
        sensorIn = inBeat;
        @(posedge sys_clk);
        #1;
        if (patternSelect inside {3'h1, 3'h2, 3'h3})
        begin
            chk(bypassOut, gen, "bypass pixel");
            chk(procOut, '0, "chain input");
            chk({14'h0, bypassSel}, 15'h0001, "bypass flag");
            chk({3'h0, finalPix}, {3'h0, gen.data}, "final pixel");
        end
        else if (patternSelect inside {3'h4, 3'h5})
        begin
            chk(procOut, gen, "chain pixel");
            chk(bypassOut, '0, "bypass idle");
            chk({3'h0, finalPix}, {3'h0, ~gen.data}, "final pixel");
        end
        else
        begin
            chk(procOut, inBeat, "sensor pass");
            chk({14'h0, bypassSel}, 15'h0000, "bypass flag");
        end
    endtask : beat

    task automatic frame(input logic [2:0] sel);
        patternSelect = sel;
        acqStart = (sel inside {[3'h1:3'h5]});
        @(posedge sys_clk);
        #1;
        if (acqStart)
            cnt = cnt + 12'h001;
        acqStart = 1'b0;
        @(posedge sys_clk);
        #1;
        for (int r = 0; r < 2; r++)
            for (int c = 0; c < 3; c++)
                beat(r == 0 && c == 0, c == 2, 12'(c), 12'(r));
        sensorIn = '0;
    endtask : frame

    task automatic results();
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_off();
        frame(3'h0);
        frame(3'h6);
    endtask : t_off

    task automatic t_patterns();
        for (int s = 1; s < 6; s++)
        begin
            frame(3'(s));
            frame(3'(s));
        end
    endtask : t_patterns

    // Brings the counter near its top so both masks and the counter itself wrap
    task automatic t_wrap();
        patternSelect = 3'h2;
        for (int i = 0; i < 4096 && cnt != 12'hFFD; i++)
        begin
            acqStart = 1'b1;
            @(posedge sys_clk);
            #1;
            acqStart = 1'b0;
            cnt = cnt + 12'h001;
            @(posedge sys_clk);
            #1;
        end
        frame(3'h3);
        frame(3'h4);
        frame(3'h5);
    endtask : t_wrap

    // Reset in mid-run clears the outputs and restarts the frame counter
    task automatic t_reset();
        frame(3'h2);
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        chk(procOut, '0, "reset chain output");
        chk(bypassOut, '0, "reset bypass output");
        chk({14'h0, bypassSel}, 15'h0000, "reset bypass flag");
        rst = 1'b0;
        cnt = 12'h000;
        @(posedge sys_clk);
        #1;
        frame(3'h3);
    endtask : t_reset

    initial
    begin
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        @(posedge sys_clk);
        #1;
        t_off();
        t_patterns();
        t_wrap();
        t_reset();
        t_off();
        results();
    end

    // Cuts a hang short
    initial
    begin
        #200000;
        num_errors++;
        results();
    end
endmodule : tpg_test_pattern_generator_tb_top

`default_nettype wire
